// [gis_pkg.sv]
// Package: constants, register map and carrier types of the bus interface state block
package gis_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CFG    = 8'h00;  // Primary address, trigger source
  localparam logic [7:0] ADDR_CMD    = 8'h04;  // Software device clear and trigger strobes, write only
  localparam logic [7:0] ADDR_STAT   = 8'h08;  // Interface state, read only
  localparam logic [7:0] ADDR_STB    = 8'h0C;  // Status summary bits
  localparam logic [7:0] ADDR_PANEL  = 8'h10;  // Front panel key gate
  localparam logic [7:0] ADDR_CLRCNT = 8'h14;  // Device clear and trigger counts

  // Field positions, config register
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_TRIG_BIT = 8;

  // Field positions, status register
  localparam int ST_REM  = 0;
  localparam int ST_LLO  = 1;
  localparam int ST_TACS = 2;
  localparam int ST_LACS = 3;
  localparam int ST_SRQ  = 4;
  localparam int ST_SHOW = 5;
  localparam int ST_RQS  = 6;

  // Status byte request bit position
  localparam int STB_RQS_BIT = 6;

  // Reset values and limits
  localparam logic [4:0] ADDR_RESET = 5'h10;  // Factory address 16
  localparam logic [4:0] ADDR_MAX   = 5'h1E;  // Highest legal address, 30

  // Address display time after power-up, ms
  localparam int SHOW_MS = 1000;

  // Bus messages as decoded by the handshake front end
  typedef struct packed {
    logic       ren;      // Remote enable line level
    logic       ifc;      // Interface clear line level
    logic       atn_cmd;  // One-cycle strobe: command byte valid
    logic [7:0] cmd;      // Command byte received under attention
  } gis_bus_t;

  // Command byte groups
  localparam logic [2:0] GRP_LISTEN = 3'h1;  // 001xxxxx listen addresses
  localparam logic [2:0] GRP_TALK   = 3'h2;  // 010xxxxx talk addresses
  localparam logic [4:0] ADDR_UN    = 5'h1F; // Unlisten / untalk code
  localparam logic [7:0] CMD_GTL    = 8'h01;
  localparam logic [7:0] CMD_SDC    = 8'h04;
  localparam logic [7:0] CMD_GET    = 8'h08;
  localparam logic [7:0] CMD_LLO    = 8'h11;
  localparam logic [7:0] CMD_DCL    = 8'h14;
  localparam logic [7:0] CMD_SPE    = 8'h18;
  localparam logic [7:0] CMD_SPD    = 8'h19;

  // Indicator outputs
  typedef struct packed {
    logic remote;
    logic talk;
    logic listen;
    logic srq;
  } gis_ind_t;

endpackage : gis_pkg

// [gis_core.sv]
// Bus interface state logic: address, remote/local, talker/listener, clears, trigger, poll
`timescale 1ns/1ps

// Scope: device side of the instrument bus interface functions
// Handshake front end decodes bytes; this block sees each byte as a one-cycle strobe
// Line levels (remote enable, interface clear) arrive unsynchronised
// Local key arrives unsynchronised and bounces; the filter hides short glitches
// Trade-off: three flops plus agreement cost four cycles of latency on each pin
// Limitation: no parallel poll and no secondary addresses
// Limitation: lockout ends only by go-to-local or by remote enable going false
// Software view: six word registers on a classic register bus
// Software view: device clear and trigger may also be raised by register writes
// Counters of clears and triggers wrap silently at 16 bits
// Clock enable low freezes every register, bus acknowledge included
// Interface clear never touches address, trigger source or counters
// Status byte is registered, so the poll sees one settled value per cycle
// Request bit re-arms only once its cause has gone away

module gis_core #(
  parameter int CLK_HZ    = 10_000_000,
  parameter int SHOW_CYC  = gis_pkg::SHOW_MS * (CLK_HZ / 1000)
) (
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Bus side, from handshake front end
  input  wire gis_pkg::gis_bus_t bus_i,
  output logic                   talk_en_o,
  output logic      [7:0]        poll_byte_o,
  output logic                   srq_o,
  input  wire logic              poll_done_i,
  // Front panel
  input  wire logic              local_key_i,
  input  wire logic              panel_key_i,
  output logic                   panel_key_o,
  output gis_pkg::gis_ind_t      ind_o,
  output logic                   show_addr_o,
  // Instrument side
  input  wire logic [7:0]        summary_i,
  output logic                   dev_clear_o,
  output logic                   trigger_o
);

  // Elaboration checks: the display counter must run and the clock be sane
  if (CLK_HZ < 1000) begin : g_bad_clk
    $error("CLK_HZ must be at least 1000");
  end
  if (SHOW_CYC < 1) begin : g_bad_show
    $error("SHOW_CYC must be at least one cycle");
  end

  // Pin synchronisers for async line levels: ren, ifc, local key
  // Stage zero may go metastable; only stages one and two are compared
  logic [2:0] ren_s_r;   // Remote enable shift chain
  logic [2:0] ifc_s_r;   // Interface clear shift chain
  logic [2:0] key_s_r;   // Local key shift chain
  logic       ren_r;     // Filtered remote enable
  logic       ifc_r;     // Filtered interface clear
  logic       key_r;     // Filtered local key
  logic       key_d_r;   // Local key one cycle later, for the edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ren_s_r <= '0;
      ifc_s_r <= '0;
      key_s_r <= '0;
    end else if (ce_i) begin
      ren_s_r <= {ren_s_r[1:0], bus_i.ren};
      ifc_s_r <= {ifc_s_r[1:0], bus_i.ifc};
      key_s_r <= {key_s_r[1:0], local_key_i};
    end
  end

  // Accept a change once stages one and two agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ren_r   <= 1'b0;
      ifc_r   <= 1'b0;
      key_r   <= 1'b0;
      key_d_r <= 1'b0;
    end else if (ce_i) begin
      if (ren_s_r[1] == ren_s_r[2]) ren_r <= ren_s_r[2];
      if (ifc_s_r[1] == ifc_s_r[2]) ifc_r <= ifc_s_r[2];
      if (key_s_r[1] == key_s_r[2]) key_r <= key_s_r[2];
      key_d_r <= key_r;
    end
  end

  // Registers
  // Lockout and remote live apart: lockout survives a local key press
  logic [4:0]  addr_r;       // Primary address
  logic        trig_bus_r;   // Bus trigger is the control source
  logic        rem_r;        // Remote state
  logic        llo_r;        // Local lockout in effect
  logic        tacs_r;       // Talker active
  logic        lacs_r;       // Listener active
  logic        spoll_r;      // Serial poll mode
  logic        rqs_clr_r;    // Request bit cleared by a poll
  logic [31:0] show_cnt_r;   // Address display countdown
  logic [15:0] clr_cnt_r;    // Device clears seen
  logic [15:0] trig_cnt_r;   // Triggers issued
  logic        ack_r;        // Bus acknowledge
  logic [31:0] rdat_r;       // Registered read data

  // Command decode; address commands compare five low bits
  // Other listen addresses leave us alone; any other talk address steals talker
  wire       cmd_v    = ce_i & bus_i.atn_cmd;
  wire [2:0] grp      = bus_i.cmd[7:5];
  wire [4:0] cmd_adr  = bus_i.cmd[4:0];
  wire       my_la    = cmd_v & (grp == gis_pkg::GRP_LISTEN) & (cmd_adr == addr_r);
  wire       my_ta    = cmd_v & (grp == gis_pkg::GRP_TALK) & (cmd_adr == addr_r);
  wire       unl      = cmd_v & (grp == gis_pkg::GRP_LISTEN) & (cmd_adr == gis_pkg::ADDR_UN);
  wire       unt      = cmd_v & (grp == gis_pkg::GRP_TALK) & (cmd_adr == gis_pkg::ADDR_UN);
  wire       other_ta = cmd_v & (grp == gis_pkg::GRP_TALK) & ~my_ta & ~unt;
  // Addressed commands count only while we listen
  wire       c_gtl    = cmd_v & (bus_i.cmd == gis_pkg::CMD_GTL) & lacs_r;
  wire       c_sdc    = cmd_v & (bus_i.cmd == gis_pkg::CMD_SDC) & lacs_r;
  wire       c_get    = cmd_v & (bus_i.cmd == gis_pkg::CMD_GET) & lacs_r;
  // Universal commands reach every device on the bus
  wire       c_llo    = cmd_v & (bus_i.cmd == gis_pkg::CMD_LLO);
  wire       c_dcl    = cmd_v & (bus_i.cmd == gis_pkg::CMD_DCL);
  wire       c_spe    = cmd_v & (bus_i.cmd == gis_pkg::CMD_SPE);
  wire       c_spd    = cmd_v & (bus_i.cmd == gis_pkg::CMD_SPD);
  wire       key_rise = ce_i & key_r & ~key_d_r;

  // Bus writes and reads
  // A request is taken once; the pending ack masks the still-held strobe,
  // so each write lands exactly one time
  wire        wb_req  = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wb_wr   = wb_req & wb_we_i & ce_i;
  wire        cfg_wr  = wb_wr & (wb_adr_i == gis_pkg::ADDR_CFG);
  wire        cmd_wr  = wb_wr & (wb_adr_i == gis_pkg::ADDR_CMD);
  wire        adr_ok  = wb_dat_i[4:0] <= gis_pkg::ADDR_MAX;
  wire        sw_dcl  = cmd_wr & wb_sel_i[0] & wb_dat_i[0];
  wire        sw_get  = cmd_wr & wb_sel_i[0] & wb_dat_i[1];

  // Primary address and trigger source; interface clear never touches them
  // An out-of-range value keeps the old address, so the bus never loses us
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_r     <= gis_pkg::ADDR_RESET;
      trig_bus_r <= 1'b0;
    end else if (cfg_wr) begin
      if (wb_sel_i[0] && adr_ok) addr_r <= wb_dat_i[4:0];
      if (wb_sel_i[1]) trig_bus_r <= wb_dat_i[gis_pkg::CFG_TRIG_BIT];
    end
  end

  // Power-up address display
  // Counts down once after reset; clock enable low stretches the display
  always_ff @(posedge clk_i) begin
    if (rst_i) show_cnt_r <= 32'(SHOW_CYC);
    else if (ce_i && show_cnt_r != 32'h0000_0000) show_cnt_r <= show_cnt_r - 32'h0000_0001;
  end
  assign show_addr_o = (show_cnt_r != 32'h0000_0000);

  // Talker and listener states
  // Interface clear wins over any command in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tacs_r <= 1'b0;
      lacs_r <= 1'b0;
    end else if (ce_i) begin
      if (ifc_r) begin
        tacs_r <= 1'b0;
        lacs_r <= 1'b0;
      end else begin
        if (my_ta) tacs_r <= 1'b1;
        else if (unt || other_ta || my_la) tacs_r <= 1'b0;
        if (my_la) lacs_r <= 1'b1;
        else if (unl || my_ta) lacs_r <= 1'b0;
      end
    end
  end

  // Remote, lockout; remote entry only on own listen address with enable
  // Remote enable false also ends lockout; the local key acts on its edge only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rem_r <= 1'b0;
      llo_r <= 1'b0;
    end else if (ce_i) begin
      if (ifc_r || !ren_r) begin
        rem_r <= 1'b0;
        if (!ren_r) llo_r <= 1'b0;
      end else begin
        if (my_la) rem_r <= 1'b1;
        else if (c_gtl) rem_r <= 1'b0;
        else if (key_rise && !llo_r) rem_r <= 1'b0;
        if (c_gtl) llo_r <= 1'b0;
        else if (c_llo) llo_r <= 1'b1;
      end
    end
  end

  // Serial poll mode and request-bit clear on poll completion
  // Set beats re-arm, so a poll in the cause's last cycle still clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spoll_r   <= 1'b0;
      rqs_clr_r <= 1'b0;
    end else if (ce_i) begin
      if (ifc_r || c_spd) spoll_r <= 1'b0;
      else if (c_spe) spoll_r <= 1'b1;
      if (spoll_r && tacs_r && poll_done_i) rqs_clr_r <= 1'b1;
      else if (summary_i[gis_pkg::STB_RQS_BIT] == 1'b0) rqs_clr_r <= 1'b0;
    end
  end

  // Request holds until polled or causes vanish
  wire rqs = summary_i[gis_pkg::STB_RQS_BIT] & ~rqs_clr_r;

  // Counters of clears and triggers for software
  // Wrap-around accepted; software works with differences
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_cnt_r  <= '0;
      trig_cnt_r <= '0;
    end else if (ce_i) begin
      if (dev_clear_o) clr_cnt_r <= clr_cnt_r + 16'h0001;
      if (trigger_o) trig_cnt_r <= trig_cnt_r + 16'h0001;
    end
  end

  // Clear and trigger pulses to the instrument
  // Combinational: each lasts exactly the strobe cycle
  assign dev_clear_o = c_dcl | c_sdc | sw_dcl;
  assign trigger_o   = (c_get | sw_get) & trig_bus_r;

  // Status byte always available to the poll; registered so the byte
  // holds one settled value per cycle, reloaded on every enabled cycle
  logic [7:0] poll_byte_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) poll_byte_r <= 8'h00;
    else if (ce_i) poll_byte_r <= {summary_i[7], rqs, summary_i[5:0]};
  end
  assign poll_byte_o = poll_byte_r;
  assign talk_en_o   = tacs_r;
  assign srq_o       = rqs;

  // Panel gate: only local and power keys live in remote
  assign panel_key_o = panel_key_i & ~rem_r;

  // Indicators
  assign ind_o.remote = rem_r;
  assign ind_o.talk   = tacs_r;
  assign ind_o.listen = lacs_r;
  assign ind_o.srq    = rqs;

  // Read words, one named wire per readable register
  wire [31:0] rd_cfg   = {23'h00_0000, trig_bus_r, 3'h0, addr_r};
  wire [31:0] rd_stat  = {25'h000_0000, rqs, show_addr_o, rqs, lacs_r, tacs_r,
                          llo_r, rem_r};
  wire [31:0] rd_stb   = {24'h00_0000, poll_byte_o};
  wire [31:0] rd_panel = {31'h0000_0000, panel_key_o};
  wire [31:0] rd_cnt   = {trig_cnt_r, clr_cnt_r};

  // Read mux
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (wb_adr_i)
      gis_pkg::ADDR_CFG:    rmux = rd_cfg;
      gis_pkg::ADDR_STAT:   rmux = rd_stat;
      gis_pkg::ADDR_STB:    rmux = rd_stb;
      gis_pkg::ADDR_PANEL:  rmux = rd_panel;
      gis_pkg::ADDR_CLRCNT: rmux = rd_cnt;
      default:              rmux = 32'h0000_0000;
    endcase
  end

  // Single-wait-state acknowledge; unmapped reads return zero
  // Read data is registered from the address of the taken request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= '0;
    end else if (ce_i) begin
      ack_r  <= wb_req;
      rdat_r <= rmux;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

endmodule : gis_core

// [gis_core_properties.sv]
// Checker: port relations of the bus interface state block
`timescale 1ns/1ps
module gis_core_props (
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // Register bus
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  // Bus side and panel
  input wire gis_pkg::gis_bus_t bus_i,
  input wire logic              talk_en_o,
  input wire logic              srq_o,
  input wire logic              poll_done_i,
  input wire logic              panel_key_o,
  input wire gis_pkg::gis_ind_t ind_o,
  input wire logic [7:0]        summary_i,
  input wire logic              dev_clear_o,
  input wire logic              trigger_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // One command byte under attention
  sequence cmd_s(logic [7:0] c);
    bus_i.atn_cmd && bus_i.cmd == c;
  endsequence
  // Clear line long enough to pass the synchroniser
  sequence ifc_s;
    bus_i.ifc [*6];
  endsequence
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
  AST_UNT: assert property (cmd_s(8'h5F) |=> !talk_en_o)
    else $error("talker kept after untalk");
  AST_UNL: assert property (cmd_s(8'h3F) |=> !ind_o.listen)
    else $error("listener kept after unlisten");
  AST_IFC: assert property (ifc_s |-> !ind_o.remote && !ind_o.talk && !ind_o.listen)
    else $error("states kept under clear");
  AST_REM_SRC: assert property ($rose(ind_o.remote) |->
    $past(bus_i.atn_cmd && bus_i.cmd[7:5] == gis_pkg::GRP_LISTEN))
    else $error("remote without listen address");
  AST_TALK_SRC: assert property ($rose(talk_en_o) |->
    $past(bus_i.atn_cmd && bus_i.cmd[7:5] == gis_pkg::GRP_TALK))
    else $error("talker without talk address");
  AST_PANEL: assert property (ind_o.remote && $past(ind_o.remote) |-> !panel_key_o)
    else $error("panel key passed in remote");
  AST_SRQ: assert property (srq_o && summary_i[6] && $past(summary_i[6]) && !poll_done_i
    && !$past(poll_done_i) |=> srq_o)
    else $error("request dropped early");
  AST_DCL: assert property (cmd_s(gis_pkg::CMD_DCL) |-> dev_clear_o)
    else $error("no clear on universal clear");
  AST_GET: assert property (cmd_s(gis_pkg::CMD_GET) && !ind_o.listen && !wb_stb_i |-> !trigger_o)
    else $error("trigger while not listener");
endmodule : gis_core_props

bind gis_core gis_core_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .bus_i(bus_i), .talk_en_o(talk_en_o),
  .srq_o(srq_o), .poll_done_i(poll_done_i), .panel_key_o(panel_key_o), .ind_o(ind_o),
  .summary_i(summary_i), .dev_clear_o(dev_clear_o), .trigger_o(trigger_o));

// [gis_ctl_model.sv]
// Bus controller model: decoded bus messages and poll completion
`timescale 1ns/1ps
module gis_ctl_model (
  // Clock
  input  wire logic         clk_i,
  // Bus messages
  output gis_pkg::gis_bus_t bus_o,
  output logic              poll_done_o
);
  initial begin
    bus_o = '0;
    poll_done_o = 1'b0;
  end
  // Strobe one byte, then scramble it so no stale byte lingers
  task automatic send(input logic [7:0] c);
    @(posedge clk_i);
    bus_o.cmd <= c;
    bus_o.atn_cmd <= 1'b1;
    @(posedge clk_i);
    bus_o.atn_cmd <= 1'b0;
    bus_o.cmd <= ~c;
    repeat (3) @(posedge clk_i);
  endtask : send
  // Level lines pass a synchroniser, so allow settling
  task automatic ren(input logic v);
    @(posedge clk_i);
    bus_o.ren <= v;
    repeat (6) @(posedge clk_i);
  endtask : ren
  task automatic ifc(input int n);
    @(posedge clk_i);
    bus_o.ifc <= 1'b1;
    repeat (n) @(posedge clk_i);
    bus_o.ifc <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : ifc
  task automatic poll_done;
    @(posedge clk_i);
    poll_done_o <= 1'b1;
    @(posedge clk_i);
    poll_done_o <= 1'b0;
  endtask : poll_done
endmodule : gis_ctl_model

// [tb.sv]
// Testbench: bus interface state block against a controller model
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, local_key_i, panel_key_i;
  logic ce_i;
  logic talk_en_o, srq_o, poll_done_i, panel_key_o, show_addr_o, dev_clear_o, trigger_o;
  logic [7:0]  wb_adr_i, summary_i, poll_byte_o;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  gis_pkg::gis_bus_t bus_i;
  gis_pkg::gis_ind_t ind_o;
  int fails, n_tests, n_clr, n_trg;
  // Command byte beside expected {remote, talk, listen}
  logic [10:0] rows [9] = '{{8'h50, 3'b010}, {8'h30, 3'b101}, {8'h50, 3'b110},
    {8'h5F, 3'b100}, {8'h31, 3'b100}, {8'h30, 3'b101}, {8'h3F, 3'b100},
    {8'h30, 3'b101}, {8'h01, 3'b001}};
  gis_core #(.SHOW_CYC(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .bus_i(bus_i), .talk_en_o(talk_en_o), .poll_byte_o(poll_byte_o), .srq_o(srq_o),
    .poll_done_i(poll_done_i), .local_key_i(local_key_i), .panel_key_i(panel_key_i),
    .panel_key_o(panel_key_o), .ind_o(ind_o), .show_addr_o(show_addr_o),
    .summary_i(summary_i), .dev_clear_o(dev_clear_o), .trigger_o(trigger_o));
  gis_ctl_model u_ctl (.clk_i(clk_i), .bus_o(bus_i), .poll_done_o(poll_done_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Pulse counters, since pulses last one cycle
  always @(posedge clk_i) begin
    if (dev_clear_o === 1'b1) n_clr++;
    if (trigger_o === 1'b1) n_trg++;
  end
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // Classic cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 20) begin
      fails++;
      finish_test;
    end
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic press;
    @(posedge clk_i);
    local_key_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    local_key_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : press
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, local_key_i, panel_key_i} = 6'b100001;
    ce_i = 1'b1;
    {wb_adr_i, wb_sel_i, wb_dat_i, summary_i} = {8'h00, 4'hF, 32'h0000_0000, 8'h00};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(show_addr_o, 1'b1)
    wb(0, gis_pkg::ADDR_CFG, 0);
    `CHK(rdat[4:0], 5'h10)
    u_ctl.ren(1'b1);
    foreach (rows[i]) begin
      u_ctl.send(rows[i][10:3]);
      `CHK({ind_o.remote, ind_o.talk, ind_o.listen}, rows[i][2:0])
    end
    u_ctl.send(8'h30);
    `CHK(panel_key_o, 1'b0)
    ce_i <= 1'b0;
    press;
    ce_i <= 1'b1;
    `CHK(ind_o.remote, 1'b1)
    u_ctl.send(gis_pkg::CMD_LLO);
    press;
    `CHK(ind_o.remote, 1'b1)
    u_ctl.send(8'h01);
    `CHK({ind_o.remote, panel_key_o}, 2'b01)
    panel_key_i <= 1'b0;
    @(posedge clk_i);
    `CHK(panel_key_o, 1'b0)
    panel_key_i <= 1'b1;
    u_ctl.send(8'h30);
    press;
    `CHK(ind_o.remote, 1'b0)
    u_ctl.send(8'h3F);
    u_ctl.send(gis_pkg::CMD_SDC);
    u_ctl.send(gis_pkg::CMD_GET);
    u_ctl.send(gis_pkg::CMD_DCL);
    `CHK(n_clr, 1)
    u_ctl.send(8'h30);
    u_ctl.send(gis_pkg::CMD_SDC);
    u_ctl.send(gis_pkg::CMD_GET);
    `CHK({n_clr, n_trg}, {32'd2, 32'd0})
    wb(1, gis_pkg::ADDR_CFG, 32'h0000_0110);
    u_ctl.send(gis_pkg::CMD_GET);
    `CHK(n_trg, 1)
    wb_sel_i <= 4'h2;
    wb(1, gis_pkg::ADDR_CFG, 32'h0000_0005);
    wb_sel_i <= 4'hF;
    wb(1, gis_pkg::ADDR_CFG, 32'h0000_001F);
    wb(0, gis_pkg::ADDR_CFG, 0);
    `CHK({rdat[8], rdat[4:0]}, {1'b0, 5'h10})
    wb(1, gis_pkg::ADDR_CFG, 32'h0000_001E);
    u_ctl.send(8'h5E);
    `CHK({talk_en_o, ind_o.listen}, 2'b10)
    wb(0, 8'hFC, 0);
    `CHK(rdat, 32'h0000_0000)
    u_ctl.ifc(1000);
    `CHK({ind_o.remote, ind_o.talk, ind_o.listen, talk_en_o}, 4'b0000)
    wb(0, gis_pkg::ADDR_CFG, 0);
    `CHK({rdat[4:0], show_addr_o}, {5'h1E, 1'b0})
    summary_i <= 8'h65;
    repeat (4) @(posedge clk_i);
    `CHK({srq_o, poll_byte_o}, {1'b1, 8'h65})
    u_ctl.send(gis_pkg::CMD_SPE);
    u_ctl.send(8'h5E);
    u_ctl.poll_done;
    repeat (3) @(posedge clk_i);
    `CHK({srq_o, poll_byte_o[6]}, 2'b00)
    u_ctl.send(gis_pkg::CMD_SPD);
    finish_test;
  end
endmodule : tb
